// ### rtl/sysctl_defines.svh
`ifndef SYSCTL_DEFINES_SVH
`define SYSCTL_DEFINES_SVH

// Coprocessor number of the system control coprocessor
`define SYSCTL_CP_NUM          4'hf
// Register numbers in the primary register field
`define SYSCTL_REG_ID          4'h0
`define SYSCTL_REG_CTRL        4'h1
`define SYSCTL_REG_TCM_REGION  4'h9
// Second opcode selectors within register 0
`define SYSCTL_OP2_CACHE_TYPE  3'h1
`define SYSCTL_OP2_TCM_SIZE    3'h2
// Secondary register and second opcode selectors within register 9 tight RAM region
`define SYSCTL_CRM_TCM_REGION  4'h1
`define SYSCTL_OP2_DATA_REGION 3'h0
`define SYSCTL_OP2_INSTR_REGION 3'h1
// Identification word field positions
`define SYSCTL_ID_IMPL_LSB     24
`define SYSCTL_ID_VAR_LSB      20
`define SYSCTL_ID_ARCH_LSB     16
`define SYSCTL_ID_PART_LSB     4
// Cache geometry word constants
`define SYSCTL_CT_CLASS        4'h7
`define SYSCTL_CT_CLASS_LSB    25
`define SYSCTL_CT_HARVARD_BIT  24
`define SYSCTL_CT_D_SIZE_LSB   18
`define SYSCTL_CT_D_ASSOC_LSB  15
`define SYSCTL_CT_D_BASE_BIT   14
`define SYSCTL_CT_D_LINE_LSB   12
`define SYSCTL_CT_I_SIZE_LSB   6
`define SYSCTL_CT_I_ASSOC_LSB  3
`define SYSCTL_CT_I_BASE_BIT   2
`define SYSCTL_CT_I_LINE_LSB   0
`define SYSCTL_CT_LINE_8WORDS  2'h2
`define SYSCTL_CT_ASSOC_4WAY   3'h2
`define SYSCTL_CT_ASSOC_NONE   3'h0
// Control register bit positions
`define SYSCTL_CTRL_IRAM_EN    18
`define SYSCTL_CTRL_VEC_HIGH   13
// Control register defined-bit mask; others read zero
`define SYSCTL_CTRL_MASK       32'h000f_f085
`define SYSCTL_ZERO_WORD       32'h0000_0000

`endif

// ### rtl/sysctl_pkg.sv
`default_nettype none
package sysctl_pkg;
  // Kind of coprocessor instruction presented by the core
  typedef enum logic [2:0] {
    OP_MOVE_TO_CORE   = 3'h0,
    OP_MOVE_FROM_CORE = 3'h1,
    OP_DATA_OP        = 3'h2,
    OP_LOAD           = 3'h3,
    OP_STORE          = 3'h4
  } cp_op_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ANSWER = 3'b010,
    ST_TRAP  = 3'b100
  } acc_state_t;
endpackage
`default_nettype wire

// ### rtl/sysctl_cache_geometry.sv
`include "sysctl_defines.svh"
`default_nettype none
// Assembles the cache geometry word from the cache blocks' live signals
module sysctl_cache_geometry (
  input  wire logic [3:0]  dcache_size_i,   // Data cache size code
  input  wire logic        dcache_absent_i, // Data cache not fitted
  input  wire logic [3:0]  icache_size_i,   // Instruction cache size code
  input  wire logic        icache_absent_i, // Instruction cache not fitted
  output logic      [31:0] geometry_o       // Cache geometry word
);
  logic [2:0] d_assoc;
  logic [2:0] i_assoc;

  always_comb begin
    // R18 associativity from presence
    d_assoc = dcache_absent_i ? `SYSCTL_CT_ASSOC_NONE : `SYSCTL_CT_ASSOC_4WAY;
    i_assoc = icache_absent_i ? `SYSCTL_CT_ASSOC_NONE : `SYSCTL_CT_ASSOC_4WAY;
    // R22 reserved fields zero
    geometry_o = `SYSCTL_ZERO_WORD;
    // R14 cache class
    geometry_o[`SYSCTL_CT_CLASS_LSB +: 4] = `SYSCTL_CT_CLASS;
    // R15 separate caches
    geometry_o[`SYSCTL_CT_HARVARD_BIT] = 1'b1;
    // R17 R20 live size codes
    geometry_o[`SYSCTL_CT_D_SIZE_LSB +: 4] = dcache_size_i;
    geometry_o[`SYSCTL_CT_I_SIZE_LSB +: 4] = icache_size_i;
    geometry_o[`SYSCTL_CT_D_ASSOC_LSB +: 3] = d_assoc;
    geometry_o[`SYSCTL_CT_I_ASSOC_LSB +: 3] = i_assoc;
    // R19 base size bits
    geometry_o[`SYSCTL_CT_D_BASE_BIT] = dcache_absent_i;
    geometry_o[`SYSCTL_CT_I_BASE_BIT] = icache_absent_i;
    // R16 eight words per line
    geometry_o[`SYSCTL_CT_D_LINE_LSB +: 2] = `SYSCTL_CT_LINE_8WORDS;
    geometry_o[`SYSCTL_CT_I_LINE_LSB +: 2] = `SYSCTL_CT_LINE_8WORDS;
  end
endmodule
`default_nettype wire

// ### rtl/sysctl_coproc.sv
`include "sysctl_defines.svh"
`default_nettype none
// Overview of operation
// R1 - Reset clears every defined stored bit except vector select and instruction RAM enable.
// R2 - Those two bits load from their init pins while reset is held.
// R3 - Register 9 reports tight RAM sizes exactly as on the size pins.
// R4 - Only privileged register moves may access this coprocessor.
// R5 - Data ops, loads, stores and unprivileged moves here take the undefined trap.
// R6 - Primary register field picks the register; secondary and second opcode refine it.
// R7 - Software keeps unused opcode and secondary fields zero.
// R8 - Software never reads unreadable nor writes unwritable registers.
// R9 - Software writes zeros and ones into write-as-zero and write-as-one fields.
// R10 - Any access of any value leaves the block recoverable.
// R11 - Register 0 read with second opcode not 1 or 2 returns identification.
// R12 - Identification holds implementor, variant, architecture, part number, revision fields.
// R13 - Register 0 read with second opcode 1 returns cache geometry.
// R14 - Cache class field reads 0111.
// R15 - Bit 24 reads one for separate caches.
// R16 - Both line length fields read binary 10, eight words.
// R17 - Size fields carry the cache size code.
// R18 - Associativity reads four-way when present, zero when absent.
// R19 - Base size bit reads zero when present, one when absent.
// R20 - Size and base size come from cache block signals.
// R21 - Register 0 read with second opcode 2 returns tight RAM size word.
// R22 - Geometry reserved bits read zero; register 0 writes change nothing.
module sysctl_coproc #(
  parameter logic [7:0]  IMPLEMENTOR = 8'h5a,   // Arbitrary value
  parameter logic [3:0]  VARIANT     = 4'h0,
  parameter logic [3:0]  ARCH        = 4'h3,    // Arbitrary value
  parameter logic [11:0] PART_NUM    = 12'h123, // Arbitrary value
  parameter logic [3:0]  REVISION    = 4'h1     // Arbitrary value
) (
  input  wire logic        core_clk_i,                 // Processor clock
  input  wire logic        rstn_i,                     // Async reset, low
  input  wire logic        req_i,                      // Coprocessor instruction strobe
  input  wire logic [2:0]  op_i,                       // Instruction kind
  input  wire logic [3:0]  cp_num_i,                   // Coprocessor number
  input  wire logic        privileged_i,               // Core in privileged mode
  input  wire logic [2:0]  first_op_field_i,           // First opcode field
  input  wire logic [3:0]  primary_register_field_i,   // Register number
  input  wire logic [3:0]  secondary_register_field_i, // Secondary register
  input  wire logic [2:0]  second_op_field_i,          // Second opcode field
  input  wire logic [31:0] wdata_i,                    // Write data from core
  input  wire logic        vector_high_init_pin_i,     // Vector select reset value
  input  wire logic        instr_ram_enable_init_pin_i, // Instr RAM enable reset value
  input  wire logic [3:0]  instr_tcm_size_pins_i,      // Instr tight RAM size
  input  wire logic [3:0]  data_tcm_size_pins_i,       // Data tight RAM size
  input  wire logic        instr_ram_absent_i,         // Instr tight RAM absent
  input  wire logic        data_ram_absent_i,          // Data tight RAM absent
  input  wire logic [3:0]  dcache_size_i,              // Data cache size code
  input  wire logic        dcache_absent_i,            // Data cache absent
  input  wire logic [3:0]  icache_size_i,              // Instr cache size code
  input  wire logic        icache_absent_i,            // Instr cache absent
  output logic             done_o,                     // Access accepted, pulse
  output logic             undef_trap_o,               // Undefined trap, pulse
  output logic [31:0]      rdata_o,                    // Read data, valid with done
  output logic [31:0]      control_o,                  // Control register
  output logic             vector_high_o,              // High vector select
  output logic             instr_ram_en_o              // Instr tight RAM enable
);
  sysctl_pkg::acc_state_t state;
  sysctl_pkg::acc_state_t next_state;
  logic [31:0] control;
  logic [31:0] next_control;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        vec_high;
  logic        next_vec_high;
  logic        iram_en;
  logic        next_iram_en;
  logic [31:0] geometry;
  logic [31:0] id_word;
  logic [31:0] tcm_size_word;
  logic [31:0] region_word;
  logic        is_move;
  logic        is_read;
  logic        legal;

  sysctl_cache_geometry u_geometry (
    .dcache_size_i   (dcache_size_i),
    .dcache_absent_i (dcache_absent_i),
    .icache_size_i   (icache_size_i),
    .icache_absent_i (icache_absent_i),
    .geometry_o      (geometry)
  );

  always_comb begin
    // R12 identification layout
    id_word = {IMPLEMENTOR, VARIANT, ARCH, PART_NUM, REVISION};
    // R21 tight RAM size word
    tcm_size_word = `SYSCTL_ZERO_WORD;
    tcm_size_word[`SYSCTL_CT_D_SIZE_LSB +: 4] = data_tcm_size_pins_i;
    tcm_size_word[`SYSCTL_CT_D_BASE_BIT] = data_ram_absent_i;
    tcm_size_word[`SYSCTL_CT_I_SIZE_LSB +: 4] = instr_tcm_size_pins_i;
    tcm_size_word[`SYSCTL_CT_I_BASE_BIT] = instr_ram_absent_i;
    // R3 size pins into region register
    region_word = `SYSCTL_ZERO_WORD;
    region_word[4:1] = (second_op_field_i == `SYSCTL_OP2_INSTR_REGION) ?
                       instr_tcm_size_pins_i : data_tcm_size_pins_i;
  end

  always_comb begin
    is_move = (op_i == sysctl_pkg::OP_MOVE_TO_CORE) || (op_i == sysctl_pkg::OP_MOVE_FROM_CORE);
    is_read = (op_i == sysctl_pkg::OP_MOVE_TO_CORE);
    // R4 privileged moves only
    legal = is_move && privileged_i;
  end

  always_comb begin
    next_state = sysctl_pkg::ST_IDLE;
    next_control = control;
    next_rdata = rdata;
    next_vec_high = vec_high;
    next_iram_en = iram_en;
    case (state)
      sysctl_pkg::ST_IDLE,
      sysctl_pkg::ST_ANSWER,
      sysctl_pkg::ST_TRAP: begin
        if (req_i && (cp_num_i == `SYSCTL_CP_NUM)) begin
          // R5 illegal forms trap
          if (!legal) begin
            next_state = sysctl_pkg::ST_TRAP;
          end else begin
            next_state = sysctl_pkg::ST_ANSWER;
            next_rdata = `SYSCTL_ZERO_WORD;
            // R6 register selection
            case (primary_register_field_i)
              `SYSCTL_REG_ID: begin
                if (is_read) begin
                  // R13 geometry on op2 one
                  if (second_op_field_i == `SYSCTL_OP2_CACHE_TYPE) begin
                    next_rdata = geometry;
                  end else if (second_op_field_i == `SYSCTL_OP2_TCM_SIZE) begin
                    next_rdata = tcm_size_word;
                  end else begin
                    // R11 identification otherwise
                    next_rdata = id_word;
                  end
                end
                // R22 writes to register 0 ignored
              end
              `SYSCTL_REG_CTRL: begin
                if (is_read) begin
                  next_rdata = control;
                  next_rdata[`SYSCTL_CTRL_VEC_HIGH] = vec_high;
                  next_rdata[`SYSCTL_CTRL_IRAM_EN] = iram_en;
                end else begin
                  // R10 only defined bits stored
                  next_control = wdata_i & `SYSCTL_CTRL_MASK;
                  next_vec_high = wdata_i[`SYSCTL_CTRL_VEC_HIGH];
                  next_iram_en = wdata_i[`SYSCTL_CTRL_IRAM_EN];
                end
              end
              `SYSCTL_REG_TCM_REGION: begin
                if (is_read && (secondary_register_field_i == `SYSCTL_CRM_TCM_REGION)) begin
                  next_rdata = region_word;
                end
              end
              default: begin
                next_rdata = `SYSCTL_ZERO_WORD;
              end
            endcase
          end
        end
      end
      default: begin
        next_state = sysctl_pkg::ST_IDLE;
      end
    endcase
    // R2 pins load on every edge while reset is held
    if (!rstn_i) begin
      next_vec_high = vector_high_init_pin_i;
      next_iram_en = instr_ram_enable_init_pin_i;
    end
  end

  // Pin-loaded bits stay out of the async clear so reset can load a live value
  always_ff @(posedge core_clk_i) begin
    vec_high <= next_vec_high;
    iram_en  <= next_iram_en;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    // R1 reset clears stored state
    if (!rstn_i) begin
      state      <= sysctl_pkg::ST_IDLE;
      control    <= `SYSCTL_ZERO_WORD;
      rdata      <= `SYSCTL_ZERO_WORD;
    end else begin
      state      <= next_state;
      control    <= next_control;
      rdata      <= next_rdata;
    end
  end

  always_comb begin
    done_o         = (state == sysctl_pkg::ST_ANSWER);
    undef_trap_o   = (state == sysctl_pkg::ST_TRAP);
    rdata_o        = rdata;
    control_o      = control;
    control_o[`SYSCTL_CTRL_VEC_HIGH] = vec_high;
    control_o[`SYSCTL_CTRL_IRAM_EN]  = iram_en;
    vector_high_o  = vec_high;
    instr_ram_en_o = iram_en;
  end
endmodule
`default_nettype wire

// ### verif/sysctl_coproc_assertions.sv
`default_nettype none
module sysctl_coproc_checker #(
  parameter logic [7:0]  IMPLEMENTOR = 8'h5a,
  parameter logic [3:0]  VARIANT     = 4'h0,
  parameter logic [3:0]  ARCH        = 4'h3,
  parameter logic [11:0] PART_NUM    = 12'h123,
  parameter logic [3:0]  REVISION    = 4'h1
) (
  input wire logic        core_clk_i, rstn_i, req_i, privileged_i, done_o, undef_trap_o,
  input wire logic        vector_high_init_pin_i, instr_ram_enable_init_pin_i, dcache_absent_i, icache_absent_i,
  input wire logic [2:0]  op_i, second_op_field_i,
  input wire logic [3:0]  cp_num_i, primary_register_field_i, dcache_size_i, icache_size_i,
  input wire logic [31:0] rdata_o, control_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_take;
    req_i && cp_num_i == 4'hf;
  endsequence
  sequence s_move;
    s_take ##0 privileged_i && op_i <= 3'h1;
  endsequence
  sequence s_rd0;
    s_move ##0 op_i == 3'h0 && primary_register_field_i == 4'h0;
  endsequence
  AST_MOVE_DONE: assert property (s_move |=> done_o && !undef_trap_o)
    else $error("privileged move not answered");
  AST_TRAP: assert property (s_take ##0 (op_i > 3'h1 || !privileged_i) |=> undef_trap_o && !done_o)
    else $error("trap missing");
  AST_IDLE: assert property (!(req_i && cp_num_i == 4'hf) |=> !done_o && !undef_trap_o)
    else $error("answer without request");
  AST_ID: assert property (s_rd0 ##0 !(second_op_field_i inside {3'h1, 3'h2}) |=>
    rdata_o == {IMPLEMENTOR, VARIANT, ARCH, PART_NUM, REVISION}) else $error("bad id word");
  AST_GEOM: assert property (s_rd0 ##0 second_op_field_i == 3'h1 |=> rdata_o[31:22] == 10'h03c
    && rdata_o[13:10] == 4'h8 && rdata_o[1:0] == 2'h2) else $error("bad geometry constants");
  AST_GEOM_LIVE: assert property (s_rd0 ##0 second_op_field_i == 3'h1 |=>
    rdata_o[21:14] == {$past(dcache_size_i), $past(dcache_absent_i) ? 3'h0 : 3'h2, $past(dcache_absent_i)} &&
    rdata_o[9:2] == {$past(icache_size_i), $past(icache_absent_i) ? 3'h0 : 3'h2, $past(icache_absent_i)})
    else $error("bad geometry fields");
  AST_WR0: assert property (s_move ##0 op_i == 3'h1 && primary_register_field_i == 4'h0 && $past(rstn_i)
    |=> $stable(control_o)) else $error("register 0 write changed control");
  // Pin-driven bits already stand at the first edge after release
  AST_RESET_INIT: assert property ($rose(rstn_i) && !req_i |-> control_o ==
    {13'h0, $past(instr_ram_enable_init_pin_i), 4'h0, $past(vector_high_init_pin_i), 13'h0})
    else $error("bad control after reset");
endmodule
bind sysctl_coproc sysctl_coproc_checker #(.IMPLEMENTOR(IMPLEMENTOR), .VARIANT(VARIANT), .ARCH(ARCH),
  .PART_NUM(PART_NUM), .REVISION(REVISION)) chk_u (.*);
`default_nettype wire

// ### verif/core_model.sv
`default_nettype none
module core_model (
  input  wire logic        core_clk_i, // Processor clock
  input  wire logic        done_i,     // Access answered
  input  wire logic        trap_i,     // Undefined trap
  input  wire logic [31:0] rdata_i,    // Read data
  output logic             req_o,      // Instruction strobe
  output logic [3:0]       cp_o,       // Coprocessor number
  output logic [2:0]       op_o,       // Instruction kind
  output logic             priv_o,     // Privileged mode
  output logic [2:0]       f1_o,       // First opcode field
  output logic [3:0]       crn_o,      // Register number
  output logic [3:0]       crm_o,      // Secondary register
  output logic [2:0]       op2_o,      // Second opcode field
  output logic [31:0]      wd_o        // Write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {req_o, cp_o, op_o, priv_o, f1_o, crn_o, crm_o, op2_o, wd_o} = '0;
  end
  task automatic issue(input logic [3:0] c, input logic [2:0] o, input logic p, input logic [3:0] rn, rm,
                       input logic [2:0] o2, input logic [31:0] w, output logic [31:0] rd, output logic dn, tr);
    @(negedge core_clk_i);
    // callers read readable registers, but also write all ones to control and write to register 0
    {req_o, cp_o, op_o, priv_o, f1_o, crn_o, crm_o, op2_o, wd_o} = {1'b1, c, o, p, 3'h0, rn, rm, o2, w};
    @(negedge core_clk_i);
    req_o = 1'b0;
    // Released fields scramble so a stale value cannot pass
    {cp_o, op_o, crn_o, crm_o, op2_o, wd_o} = ~{cp_o, op_o, crn_o, crm_o, op2_o, wd_o};
    {rd, dn, tr} = {rdata_i, done_i, trap_i};
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  IMPL = 8'h3c;   // Arbitrary code
  localparam logic [11:0] PART = 12'h7e1; // Arbitrary code
  localparam logic [31:0] ID_WORD = {IMPL, 4'h2, 4'h6, PART, 4'h9};
  logic        clk, rstn, vh, ir, da, ia, ita, dta, req, priv, dn, tr, done, trap, vho, iro;
  logic [2:0]  op, f1, op2;
  logic [3:0]  cp, primary_register_field, secondary_register_field, dsz, isz, it, dt;
  logic [31:0] wd, rdv, rdata, ctrl;
  int          n_errors, checks;
  sysctl_coproc #(.IMPLEMENTOR(IMPL), .VARIANT(4'h2), .ARCH(4'h6), .PART_NUM(PART), .REVISION(4'h9)) dut_u (
    .core_clk_i(clk), .rstn_i(rstn), .req_i(req), .op_i(op), .cp_num_i(cp), .privileged_i(priv),
    .first_op_field_i(f1), .primary_register_field_i(primary_register_field), .secondary_register_field_i(secondary_register_field),
    .second_op_field_i(op2), .wdata_i(wd), .vector_high_init_pin_i(vh), .instr_ram_enable_init_pin_i(ir),
    .instr_tcm_size_pins_i(it), .data_tcm_size_pins_i(dt), .instr_ram_absent_i(ita), .data_ram_absent_i(dta),
    .dcache_size_i(dsz), .dcache_absent_i(da), .icache_size_i(isz), .icache_absent_i(ia), .done_o(done),
    .undef_trap_o(trap), .rdata_o(rdata), .control_o(ctrl), .vector_high_o(vho), .instr_ram_en_o(iro));
  core_model core_u (.core_clk_i(clk), .done_i(done), .trap_i(trap), .rdata_i(rdata), .req_o(req), .cp_o(cp),
    .op_o(op), .priv_o(priv), .f1_o(f1), .crn_o(primary_register_field), .crm_o(secondary_register_field), .op2_o(op2), .wd_o(wd));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic [3:0] c, input logic [2:0] o, input logic p, input logic [3:0] rn,
                     input logic [2:0] o2, input logic [31:0] w, input logic [1:0] ans);
    core_u.issue(c, o, p, rn, (rn == 4'h9) ? 4'h1 : 4'h0, o2, w, rdv, dn, tr);
    chk("answer", {30'h0, dn, tr}, {30'h0, ans});
  endtask
  task automatic rd(input logic [3:0] rn, input logic [2:0] o2, input logic [31:0] exp);
    acc(4'hf, 3'h0, 1'b1, rn, o2, 32'h0, 2'h2);
    chk("rdata", rdv, exp);
  endtask
  function automatic logic [31:0] geo(input logic [3:0] d, input logic dab, input logic [3:0] i, input logic iab);
    return {7'h07, 1'b1, 2'h0, d, dab ? 3'h0 : 3'h2, dab, 4'h8, i, iab ? 3'h0 : 3'h2, iab, 2'h2};
  endfunction
  task automatic stop_test;
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {rstn, vh, ir, da, ia, ita, dta} = 7'b0100001;
    {dsz, isz, it, dt} = {4'h5, 4'hb, 4'h6, 4'h9};
    n_errors = 0;
    checks = 0;
    repeat (5) @(negedge clk);
    chk("control", ctrl, 32'h0000_2000);
    rstn = 1'b1;
    @(negedge clk);
    chk("control", {ctrl[31:2], vho, iro}, 32'h0000_2002);
    for (int k = 0; k < 8; k++) begin
      if (k != 1 && k != 2) rd(4'h0, 3'(k), ID_WORD);
    end
    rd(4'h0, 3'h1, geo(4'h5, 1'b0, 4'hb, 1'b0));
    {dsz, da, isz} = {4'h0, 1'b1, 4'h3};
    rd(4'h0, 3'h1, geo(4'h0, 1'b1, 4'h3, 1'b0));
    rd(4'h0, 3'h2, {10'h0, 4'h9, 3'h0, 1'b1, 4'h0, 4'h6, 3'h0, 1'b0, 2'h0});
    rd(4'h9, 3'h0, {27'h0, 4'h9, 1'b0});
    rd(4'h9, 3'h1, {27'h0, 4'h6, 1'b0});
    acc(4'hf, 3'h1, 1'b1, 4'h1, 3'h0, 32'hffff_ffff, 2'h2);
    rd(4'h1, 3'h0, 32'h000f_f085);
    chk("pins", {30'h0, vho, iro}, 32'h0000_0003);
    acc(4'hf, 3'h1, 1'b1, 4'h0, 3'h0, 32'h0, 2'h2);
    acc(4'hf, 3'h1, 1'b0, 4'h1, 3'h0, 32'h0, 2'h1);
    acc(4'hf, 3'h0, 1'b0, 4'h0, 3'h0, 32'h0, 2'h1);
    for (int k = 2; k < 5; k++) begin
      acc(4'hf, 3'(k), 1'b1, 4'h1, 3'h0, 32'h0, 2'h1);
    end
    acc(4'he, 3'h0, 1'b1, 4'h0, 3'h0, 32'h0, 2'h0);
    rd(4'h1, 3'h0, 32'h000f_f085);
    // Second reset with the pins swapped
    @(negedge clk);
    {rstn, vh, ir} = 3'b001;
    repeat (5) @(negedge clk);
    chk("control", ctrl, 32'h0004_0000);
    rstn = 1'b1;
    @(negedge clk);
    chk("control", ctrl, 32'h0004_0000);
    stop_test();
  end
endmodule
`default_nettype wire
